//--- rtl/card_timing_pkg.sv
// card_timing_pkg: register addresses, reset values and sizes for the
// smart card timing and reset block.
// assumes a byte-wide mpu data memory bus with 16-bit addresses.
// Functional notes
// R1: bypass mode lets firmware drive and sample card io directly, skipping the uart.
// R2: in bypass, software handles answer, first char, parity, break and crc itself.
// R3: sync mode derives card clock from the etu counter and divider settings.
// R4: sync mode samples input on clock rise and changes output on clock fall.
// R5: sync clock appears only on the selected interface; software must select it.
// R6: received bytes queue in a fifo; each data read pops one; resets zero.
// R7: block wait is 28 bits from four bytes; top byte uses low four bits.
// R8: t1 times last sent char start to first received start; flags overrun.
// R9: t0 uses same value as work wait between any consecutive char edges.
// R10: block or work wait expiry raises an event to the processor.
// R11: 16-bit char or initial wait between received start edges; expiry signals.
// R12: software loads char or initial wait early and tracks which it holds.
// R13: 16-bit answer timeout bounds first to last answer character edge.
// R14: answer timer armed by receive flag, starts at first start bit, stops clearing.
// R15: 8-bit first char timeout starts at reset release; mute card gives answer timeout.
// R16: reset length register, reset value 0x70, delays card reset release in etus.
// R17: zero length with hold clear releases reset once supply good asserts.
// R18: setting hold drives card reset low; clearing releases after programmed delay.
// R19: hold set before power keeps reset asserted until delay after clearing.
// R20: software should load block wait before the last transmit byte.
// R21: all timers advance on etu ticks and restart on their start events.
package card_timing_pkg;
   localparam logic [15:0] ADDR_RX_DATA  = 16'hFE09;
   localparam logic [15:0] ADDR_BWT3     = 16'hFE18;
   localparam logic [15:0] ADDR_BWT2     = 16'hFE19;
   localparam logic [15:0] ADDR_BWT1     = 16'hFE1A;
   localparam logic [15:0] ADDR_BWT0     = 16'hFE1B;
   localparam logic [15:0] ADDR_CWT_HI   = 16'hFE1C;
   localparam logic [15:0] ADDR_CWT_LO   = 16'hFE1D;
   localparam logic [15:0] ADDR_ATR_HI   = 16'hFE1F;
   localparam logic [15:0] ADDR_ATR_LO   = 16'hFE20;
   localparam logic [15:0] ADDR_TS_TO    = 16'hFE21;
   localparam logic [15:0] ADDR_RST_LEN  = 16'hFE22;
   localparam logic [7:0]  REG_RESET     = 8'h00;
   localparam logic [7:0]  RST_LEN_RESET = 8'h70;
   localparam logic [3:0]  BWT3_MASK     = 4'hF;
   localparam int          FIFO_DEPTH    = 32;
   localparam int          FIFO_WIDTH    = 8;
   localparam logic [3:0]  RX_LAST_BIT   = 4'h9;
   localparam logic [3:0]  TX_FRAME_BITS = 4'hB;
   localparam int          TIMER_COUNT   = 4;
   localparam int          CNT_W         = 28;
endpackage : card_timing_pkg

//--- rtl/card_timing_reset.sv
// card_timing_reset: etu generation, waiting-time timers, card reset
// sequencing, sync clock, bypass and the receive fifo read port.
// assumes card pins are wired open drain outside and that the card
// external clock is asynchronous to core_clk.
`timescale 1ns/1ps
`default_nettype none

// receive fifo, flip-flop storage, depth must be a power of two
module rx_byte_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 32
) (
   // clock and reset
   input  wire logic             core_clk,
   input  wire logic             rst_n,
   // fill side
   input  wire logic [WIDTH-1:0] in_data,
   input  wire logic             in_valid,
   output logic                  in_ready,
   // drain side
   output logic      [WIDTH-1:0] out_data,
   output logic                  out_valid,
   input  wire logic             out_ready
);
   localparam int AW = $clog2(DEPTH);
   // elaboration-time refusal of depths the pointer wrap cannot serve
   if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
      $error("fifo depth must be a power of two");
   end
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr;
   logic [AW-1:0]    rd_ptr;
   logic [AW:0]      fill;
   wire              push = in_valid & in_ready;
   wire              pop  = out_valid & out_ready;
   // honest flags from the fill count
   assign in_ready  = (fill != (AW+1)'(DEPTH));
   assign out_valid = (fill != '0);
   assign out_data  = mem[rd_ptr];
   // pointers and count
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         fill   <= '0;
      end else begin
         if (push) wr_ptr <= wr_ptr + 1'b1;
         if (pop) rd_ptr <= rd_ptr + 1'b1;
         fill <= fill + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
   // storage, no reset needed on data
   always_ff @(posedge core_clk) begin
      if (push) mem[wr_ptr] <= in_data;
   end
endmodule : rx_byte_fifo

module card_timing_reset (
   // clock and reset
   input  wire logic        core_clk,
   input  wire logic        rst_n,
   // mpu data memory bus
   input  wire logic [15:0] bus_addr,
   input  wire logic        bus_wr,
   input  wire logic        bus_rd,
   input  wire logic [7:0]  bus_wdata,
   output logic      [7:0]  bus_rdata,
   // control levels from the card control logic
   input  wire logic        protocol_t1,
   input  wire logic        sync_mode,
   input  wire logic        iface_select,
   input  wire logic        bypass_mode,
   input  wire logic        answer_receive_flag,
   input  wire logic        first_char_detect_enable,
   input  wire logic        card_reset_hold,
   input  wire logic        card_supply_good,
   input  wire logic [15:0] etu_divisor_setting,
   input  wire logic [7:0]  card_clock_divider,
   input  wire logic        card_ext_clock_divider,
   // firmware bypass
   input  wire logic        bypass_io_drive,
   input  wire logic        bypass_io_level,
   output logic             bypass_io_sample,
   // transmit byte source
   input  wire logic [7:0]  tx_data,
   input  wire logic        tx_valid,
   output logic             tx_ready,
   // card pins
   input  wire logic        card_io_in,
   output logic             card_io_out,
   output logic             card_io_oe,
   output logic             card_clk,
   output logic             card_rst_n,
   input  wire logic        card_ext_clk,
   // events
   output logic             wait_timeout,
   output logic             char_timeout,
   output logic             answer_timeout,
   output logic             rx_overrun
);
   localparam int NT = card_timing_pkg::TIMER_COUNT;
   localparam int CW = card_timing_pkg::CNT_W;

   // register file
   logic [7:0] block_wait_count [4];
   logic [7:0] cwt_hi, cwt_lo, atr_hi, atr_lo, ts_to, rst_len;

   // pin synchronisers: first stage read only by the second
   logic io_m, io_s, io_p, xc_m, xc_s, xc_p;
   always_ff @(posedge core_clk) begin
      io_m <= card_io_in;
      io_s <= io_m;
      io_p <= io_s;
      xc_m <= card_ext_clk;
      xc_s <= xc_m;
      xc_p <= xc_s;
   end
   assign bypass_io_sample = io_s;

   // etu counter: core clock or external clock edges as the time base
   logic [15:0] etu_cnt;
   logic        rx_start;
   wire         etu_src  = card_ext_clock_divider ? (xc_s & ~xc_p) : 1'b1;
   wire         etu_tick = etu_src & (etu_cnt >= etu_divisor_setting);
   wire         etu_half = etu_src & (etu_cnt == (etu_divisor_setting >> 1));
   // restart on a start edge so bit samples land mid etu
   always_ff @(posedge core_clk) begin
      if (!rst_n || rx_start || etu_tick) etu_cnt <= '0;
      else if (etu_src) etu_cnt <= etu_cnt + 16'h0001;
   end

   // sync clock from etu ticks, only on the selected interface
   logic [7:0] sclk_cnt;
   logic       sclk;
   wire        sync_on   = sync_mode & iface_select;
   wire        sclk_step = sync_on & etu_tick & (sclk_cnt == card_clock_divider);
   wire        sclk_rise = sclk_step & ~sclk;
   wire        sclk_fall = sclk_step & sclk;
   // R3 etu derived clock
   always_ff @(posedge core_clk) begin
      if (!rst_n || !sync_on) begin
         sclk_cnt <= '0;
         sclk     <= 1'b0;
      end else if (etu_tick) begin
         sclk_cnt <= sclk_step ? 8'h00 : sclk_cnt + 8'h01;
         if (sclk_step) sclk <= ~sclk;
      end
   end
   // R5 clock gated by selection
   assign card_clk = sclk & sync_on;

   // receiver: async frames sampled mid etu, sync bits on clock rise
   typedef enum {RX_IDLE, RX_BITS} rx_state_e;
   rx_state_e  rx_state;
   logic [3:0] rx_bit;
   logic [7:0] rx_shift;
   logic       rx_push;
   logic       tx_busy;
   wire        rx_fall  = io_p & ~io_s;
   wire        rx_samp  = sync_on ? sclk_rise : etu_half;
   wire        rx_en    = ~bypass_mode & ~tx_busy;
   assign rx_start = rx_en & (rx_state == RX_IDLE) & (sync_on ? sclk_rise : rx_fall);
   wire        rx_last  = sync_on ? (rx_bit == 4'h7) : (rx_bit == card_timing_pkg::RX_LAST_BIT);
   wire        rx_abort = ~sync_on & (rx_bit == 4'h0) & io_s;
   // R4 sample on rising clock in sync mode
   always_ff @(posedge core_clk) begin
      rx_push <= 1'b0;
      if (!rst_n || !rx_en) begin
         rx_state <= RX_IDLE;
         rx_bit   <= '0;
         rx_shift <= '0;
      end else begin
         case (rx_state)
            RX_IDLE: begin
               rx_bit <= '0;
               if (rx_start) rx_state <= RX_BITS;
               if (rx_start && sync_on) begin
                  rx_shift <= {io_s, rx_shift[7:1]};
                  rx_bit   <= 4'h1;
               end
            end
            RX_BITS: begin
               if (rx_samp) begin
                  rx_bit <= rx_bit + 4'h1;
                  if (rx_abort) rx_state <= RX_IDLE;
                  else if (sync_on || (rx_bit != 4'h0 && !rx_last)) rx_shift <= {io_s, rx_shift[7:1]};
                  if (rx_last) begin
                     rx_push  <= 1'b1;
                     rx_state <= RX_IDLE;
                  end
               end
            end
            default: rx_state <= RX_IDLE;
         endcase
      end
   end

   // receive fifo, read through the data register
   logic       f_in_ready, f_valid;
   logic [7:0] f_data;
   wire        rd_rx = bus_rd & (bus_addr == card_timing_pkg::ADDR_RX_DATA);
   rx_byte_fifo #(
      .WIDTH (card_timing_pkg::FIFO_WIDTH),
      .DEPTH (card_timing_pkg::FIFO_DEPTH)
   ) u_fifo (
      .core_clk  (core_clk),
      .rst_n     (rst_n),
      .in_data   (rx_shift),
      .in_valid  (rx_push),
      .in_ready  (f_in_ready),
      .out_data  (f_data),
      .out_valid (f_valid),
      .out_ready (rd_rx)
   );

   // transmitter: start, 8 data, even parity, stop; sync changes on fall
   logic [10:0] tx_shift;
   logic [3:0]  tx_left;
   wire         tx_take = tx_valid & tx_ready;
   wire         tx_step = sync_on ? sclk_fall : etu_tick;
   assign tx_ready = ~tx_busy & ~bypass_mode & (rx_state == RX_IDLE);
   // R4 outgoing bits move on falling clock in sync mode
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         tx_busy  <= 1'b0;
         tx_shift <= '1;
         tx_left  <= '0;
      end else if (tx_take) begin
         tx_busy  <= 1'b1;
         tx_shift <= {1'b1, ^tx_data, tx_data, 1'b0};
         tx_left  <= card_timing_pkg::TX_FRAME_BITS;
      end else if (tx_busy && tx_step) begin
         tx_shift <= {1'b1, tx_shift[10:1]};
         tx_left  <= tx_left - 4'h1;
         if (tx_left == 4'h1) tx_busy <= 1'b0;
      end
   end

   // io pin: open drain low while sending zero, firmware owns it in bypass
   // R1 firmware drives io
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         card_io_out <= 1'b1;
         card_io_oe  <= 1'b0;
      end else begin
         card_io_out <= bypass_mode ? bypass_io_level : 1'b0;
         card_io_oe  <= bypass_mode ? bypass_io_drive : (tx_busy & ~tx_shift[0]);
      end
   end

   // card reset sequencing
   typedef enum {RST_HELD, RST_DELAY, RST_OFF} rst_state_e;
   rst_state_e rst_state;
   logic [7:0] rst_cnt;
   wire        rst_keep    = card_reset_hold | ~card_supply_good;
   wire        rst_release = (rst_state != RST_OFF) & ~rst_keep
                             & ((rst_len == 8'h00) | ((rst_state == RST_DELAY) & etu_tick & (rst_cnt + 8'h01 >= rst_len)));
   // R18 hold forces reset, R17 R19 release after delay
   always_ff @(posedge core_clk) begin
      if (!rst_n || rst_keep) begin
         rst_state <= RST_HELD;
         rst_cnt   <= '0;
      end else begin
         case (rst_state)
            RST_HELD:  rst_state <= rst_release ? RST_OFF : RST_DELAY;
            RST_DELAY: begin
               if (etu_tick) rst_cnt <= rst_cnt + 8'h01;
               if (rst_release) rst_state <= RST_OFF;
            end
            RST_OFF:   rst_state <= RST_OFF;
            default:   rst_state <= RST_HELD;
         endcase
      end
   end
   assign card_rst_n = (rst_state == RST_OFF);

   // timer starts, stops and limits: 0 block/work, 1 char, 2 answer, 3 first char
   logic          atr_seen;
   logic [NT-1:0] t_start, t_stop, t_run, t_fire;
   logic [CW-1:0] t_lim [NT];
   logic [CW-1:0] t_cnt [NT];
   wire           tx_evt = tx_take;
   // R7 28-bit value, top byte low nibble
   assign t_lim[0] = {block_wait_count[3][3:0] & card_timing_pkg::BWT3_MASK, block_wait_count[2], block_wait_count[1], block_wait_count[0]};
   assign t_lim[1] = {12'h000, cwt_hi, cwt_lo};
   assign t_lim[2] = {12'h000, atr_hi, atr_lo};
   assign t_lim[3] = {20'h00000, ts_to};
   // R8 block wait in t1, R9 work wait in t0
   assign t_start[0] = protocol_t1 ? tx_evt : (tx_evt | rx_start);
   assign t_stop[0]  = protocol_t1 & rx_start;
   // R11 between received start edges
   assign t_start[1] = rx_start;
   assign t_stop[1]  = tx_evt;
   // R14 armed by receive flag, first start bit
   assign t_start[2] = answer_receive_flag & rx_start & ~atr_seen;
   assign t_stop[2]  = ~answer_receive_flag;
   // R15 from reset release until first char edge
   assign t_start[3] = rst_release & first_char_detect_enable;
   assign t_stop[3]  = rx_start | ~first_char_detect_enable;
   always_ff @(posedge core_clk) begin
      if (!rst_n || !answer_receive_flag) atr_seen <= 1'b0;
      else if (rx_start) atr_seen <= 1'b1;
   end

   // R21 shared etu tick drives every timer
   genvar gi;
   generate
      for (gi = 0; gi < NT; gi++) begin : g_timer
         assign t_fire[gi] = t_run[gi] & etu_tick & (t_cnt[gi] == t_lim[gi]) & ~t_start[gi] & ~t_stop[gi];
         always_ff @(posedge core_clk) begin
            if (!rst_n) begin
               t_run[gi] <= 1'b0;
               t_cnt[gi] <= '0;
            end else if (t_start[gi]) begin
               t_run[gi] <= 1'b1;
               t_cnt[gi] <= '0;
            end else if (t_stop[gi] || t_fire[gi]) begin
               t_run[gi] <= 1'b0;
            end else if (t_run[gi] && etu_tick) begin
               t_cnt[gi] <= t_cnt[gi] + 1'b1;
            end
         end
      end
   endgenerate

   // event pulses, one cycle each
   // R10 R13 expiry events
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         wait_timeout   <= 1'b0;
         char_timeout   <= 1'b0;
         answer_timeout <= 1'b0;
         rx_overrun     <= 1'b0;
      end else begin
         wait_timeout   <= t_fire[0];
         char_timeout   <= t_fire[1];
         answer_timeout <= t_fire[2] | t_fire[3];
         rx_overrun     <= rx_push & ~f_in_ready;
      end
   end

   // register writes
   // R16 reset length resets to 0x70
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         for (int i = 0; i < 4; i++) block_wait_count[i] <= card_timing_pkg::REG_RESET;
         cwt_hi  <= card_timing_pkg::REG_RESET;
         cwt_lo  <= card_timing_pkg::REG_RESET;
         atr_hi  <= card_timing_pkg::REG_RESET;
         atr_lo  <= card_timing_pkg::REG_RESET;
         ts_to   <= card_timing_pkg::REG_RESET;
         rst_len <= card_timing_pkg::RST_LEN_RESET;
      end else if (bus_wr) begin
         case (bus_addr)
            card_timing_pkg::ADDR_BWT0:    block_wait_count[0]  <= bus_wdata;
            card_timing_pkg::ADDR_BWT1:    block_wait_count[1]  <= bus_wdata;
            card_timing_pkg::ADDR_BWT2:    block_wait_count[2]  <= bus_wdata;
            card_timing_pkg::ADDR_BWT3:    block_wait_count[3]  <= {4'h0, bus_wdata[3:0]};
            card_timing_pkg::ADDR_CWT_HI:  cwt_hi  <= bus_wdata;
            card_timing_pkg::ADDR_CWT_LO:  cwt_lo  <= bus_wdata;
            card_timing_pkg::ADDR_ATR_HI:  atr_hi  <= bus_wdata;
            card_timing_pkg::ADDR_ATR_LO:  atr_lo  <= bus_wdata;
            card_timing_pkg::ADDR_TS_TO:   ts_to   <= bus_wdata;
            card_timing_pkg::ADDR_RST_LEN: rst_len <= bus_wdata;
            default: ;
         endcase
      end
   end

   // read mux, registered; empty fifo reads zero, unmapped reads zero
   logic [7:0] rd_mux;
   always_comb begin
      case (bus_addr)
         card_timing_pkg::ADDR_RX_DATA: rd_mux = f_valid ? f_data : 8'h00;
         card_timing_pkg::ADDR_BWT0:    rd_mux = block_wait_count[0];
         card_timing_pkg::ADDR_BWT1:    rd_mux = block_wait_count[1];
         card_timing_pkg::ADDR_BWT2:    rd_mux = block_wait_count[2];
         card_timing_pkg::ADDR_BWT3:    rd_mux = block_wait_count[3];
         card_timing_pkg::ADDR_CWT_HI:  rd_mux = cwt_hi;
         card_timing_pkg::ADDR_CWT_LO:  rd_mux = cwt_lo;
         card_timing_pkg::ADDR_ATR_HI:  rd_mux = atr_hi;
         card_timing_pkg::ADDR_ATR_LO:  rd_mux = atr_lo;
         card_timing_pkg::ADDR_TS_TO:   rd_mux = ts_to;
         card_timing_pkg::ADDR_RST_LEN: rd_mux = rst_len;
         default:                       rd_mux = 8'h00;
      endcase
   end
   // R6 each read pops one byte
   always_ff @(posedge core_clk) begin
      if (!rst_n) bus_rdata <= card_timing_pkg::REG_RESET;
      else if (bus_rd) bus_rdata <= rd_mux;
   end

   // checks
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   hold_forces_reset_a: assert property (card_reset_hold |=> !card_rst_n) // R18
      else $error("card reset not held low");
   zero_delay_a: assert property (rst_state == RST_HELD && !rst_keep && rst_len == 8'h00 |=> card_rst_n) // R17
      else $error("zero length release late");
   release_cause_a: assert property ($rose(card_rst_n) |-> !$past(card_reset_hold) && $past(card_supply_good)) // R19
      else $error("reset released while held");
   fifo_pop_a: assert property (rd_rx && f_valid |=> bus_rdata == $past(f_data)) // R6
      else $error("rx read did not return fifo head");
   sync_clk_gate_a: assert property (!sync_on |=> !card_clk) // R5
      else $error("card clock without selected sync");
   sync_clk_tick_a: assert property (sync_on && $past(sync_on) && $changed(card_clk) |-> $past(etu_tick)) // R3
      else $error("card clock moved off an etu tick");
   block_wait_a: assert property (wait_timeout |-> $past(t_cnt[0]) == $past(t_lim[0]) && $past(etu_tick)) // R8
      else $error("block wait fired at wrong count");
   answer_off_a: assert property (!answer_receive_flag |=> !t_run[2]) // R14
      else $error("answer timer running while disarmed");
   ts_off_a: assert property (!first_char_detect_enable |=> !t_run[3]) // R15
      else $error("first char timer running while disabled");
   bypass_drive_a: assert property (bypass_mode |=> card_io_oe == $past(bypass_io_drive)) // R1
      else $error("bypass drive not followed");
   cov_wait_c: cover property (wait_timeout);
   cov_answer_c: cover property (answer_timeout);
   cov_push_c: cover property (rx_push && f_in_ready);
   cov_release_c: cover property ($rose(card_rst_n));
endmodule : card_timing_reset

`default_nettype wire

//--- sim/card_model.sv
// card_model: behavioural card on the io line, sends framed bytes on request
// assumes an open-drain io with a pull-up and a fixed bit time in ns
`timescale 1ns/1ps
`default_nettype none
module card_model #(
   parameter int BIT_NS = 3200
) (
   // io pin pieces of the block
   input  wire logic card_io_out,
   input  wire logic card_io_oe,
   output logic      card_io_in
);
   logic card_low = 1'b0;
   // wired-and of both drivers; a released line floats up to the pull-up
   assign card_io_in = !(card_low || (card_io_oe === 1'b1 && card_io_out === 1'b0));
   // start, data lsb first, even parity, stop, then one guard bit time
   task automatic send_byte(input logic [7:0] b);
      logic [10:0] frame;
      frame = {1'b1, ^b, b, 1'b0};
      for (int i = 0; i < 11; i++) begin
         card_low = !frame[i];
         #(BIT_NS);
      end
      #(BIT_NS);
   endtask : send_byte
endmodule : card_model
`default_nettype wire

//--- sim/tb_top.sv
// tb_top: self-checking bench for the card timing and reset block
// assumes the card model on io; one etu is four card clocks, 32 core cycles
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   localparam logic [15:0] RX = card_timing_pkg::ADDR_RX_DATA;
   logic        core_clk = '0, card_ext_clk = '0, rst_n = '0, bus_wr = '0, bus_rd = '0, rd_q = '0, clk_q = '0;
   logic        flag = '0, ts_en = '0, hold = 1'b1, good = '0, sync = '0, sel = '0, byp = '0, drv = '0, lvl = '0;
   logic        t1 = 1'b1;
   logic        tx_valid = '0, tx_ready, io_in, io_out, io_oe, card_clk, card_rst_n, smp, w_to, c_to, a_to, ovr;
   logic [15:0] bus_addr = '0;
   logic [7:0]  bus_wdata = '0, tx_data = '0, d = '0, bus_rdata, exp_q[$], rxq[$];
   logic [7:0]  n_wait = '0, n_char = '0, n_ans = '0, n_ovr = '0, n_clk = '0, e_wait = '0, e_char = '0, e_ans = '0;
   int          n_errors = 0, n_compared = 0, cycles = 0, seed = 32'hA4F15507;

   card_timing_reset i_dut (
      .core_clk, .rst_n, .bus_addr, .bus_wr, .bus_rd, .bus_wdata, .bus_rdata,
      .protocol_t1(t1), .sync_mode(sync), .iface_select(sel), .bypass_mode(byp),
      .answer_receive_flag(flag), .first_char_detect_enable(ts_en), .card_reset_hold(hold),
      .card_supply_good(good), .etu_divisor_setting(16'h0003), .card_clock_divider(8'h00),
      .card_ext_clock_divider(1'b1), .bypass_io_drive(drv), .bypass_io_level(lvl), .bypass_io_sample(smp),
      .tx_data, .tx_valid, .tx_ready, .card_io_in(io_in), .card_io_out(io_out), .card_io_oe(io_oe),
      .card_clk, .card_rst_n, .card_ext_clk, .wait_timeout(w_to), .char_timeout(c_to),
      .answer_timeout(a_to), .rx_overrun(ovr));
   card_model i_card (.card_io_out(io_out), .card_io_oe(io_oe), .card_io_in(io_in));

   // core clock 100 ns; card clock 800 ns with an unrelated phase
   always #50 core_clk = ~core_clk;
   initial #37 forever #400 card_ext_clk = ~card_ext_clk;

   // events and clock rises are tallied; a hang is cut off by the cycle ceiling
   always @(posedge core_clk) begin
      cycles++;
      if (rst_n) begin
         rd_q <= bus_rd;
         clk_q <= card_clk;
         n_wait <= n_wait + 8'(w_to);
         n_char <= n_char + 8'(c_to);
         n_ans <= n_ans + 8'(a_to);
         n_ovr <= n_ovr + 8'(ovr);
         n_clk <= n_clk + 8'(card_clk & ~clk_q);
      end
      if (cycles == 40000) begin
         n_errors++;
         close_out();
      end
   end
   // read data is registered, so it is taken from the queue half a cycle after the strobe
   always @(negedge core_clk) if (rd_q) check(bus_rdata, exp_q.pop_front());

   task automatic step(input int n = 1);
      repeat (n) @(posedge core_clk);
      #1;
   endtask : step
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_errors++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   // strobes get a quiet cycle after them so no signal changes twice in one step
   task automatic wr(input logic [15:0] a, input logic [7:0] v);
      bus_addr = a;
      bus_wdata = v;
      bus_wr = 1'b1;
      step();
      bus_wr = 1'b0;
      step();
   endtask : wr
   task automatic rd(input logic [15:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      bus_addr = a;
      bus_rd = 1'b1;
      step();
      bus_rd = 1'b0;
      step();
   endtask : rd
   task automatic events();
      check(n_wait, e_wait);
      check(n_char, e_char);
      check(n_ans, e_ans);
   endtask : events
   task automatic send(input int n);
      logic [7:0] b;
      repeat (n) begin
         b = 8'($random(seed));
         rxq.push_back(b);
         i_card.send_byte(b);
      end
   endtask : send
   // empty the fifo, then one more read must give zero
   task automatic drain();
      while (rxq.size() > 0) rd(RX, rxq.pop_front());
      rd(RX, 8'h00);
   endtask : drain
   // hold the byte until the edge that sees ready, then wait out the 11 etu frame
   task automatic send_tx();
      tx_data = 8'($random(seed));
      tx_valid = 1'b1;
      while (tx_ready !== 1'b1) step();
      step();
      tx_valid = 1'b0;
      step(32 * 12);
   endtask : send_tx
   task automatic close_out();
      if (n_errors == 0 && n_compared > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : close_out

   // main sequence
   initial begin
      step(12);
      rst_n = 1'b1;
      step(3);
      for (int a = 16'hFE18; a <= 16'hFE22; a++) rd(16'(a), (a == 16'hFE22) ? 8'h70 : 8'h00);
      rd(RX, 8'h00);
      wr(RX, 8'h5A);
      for (int a = 16'hFE18; a <= 16'hFE22; a++) begin
         d = 8'($random(seed));
         wr(16'(a), d);
         rd(16'(a), (a == 16'hFE1E) ? 8'h00 : (a == 16'hFE18) ? (d & 8'h0F) : d);
      end
      rd(RX, 8'h00);
      // supply comes up with hold set, then a 5 etu release and a mute card
      good = 1'b1;
      step(32 * 4);
      check(8'(card_rst_n), 8'h00);
      wr(16'hFE22, 8'h05);
      wr(16'hFE21, 8'h06);
      ts_en = 1'b1;
      hold = 1'b0;
      step(32 * 3);
      check(8'(card_rst_n), 8'h00);
      step(32 * 4);
      check(8'(card_rst_n), 8'h01);
      step(32 * 10);
      e_ans++;
      events();
      hold = 1'b1;
      ts_en = 1'b0;
      step(2);
      check(8'(card_rst_n), 8'h00);
      wr(16'hFE22, 8'h00);
      hold = 1'b0;
      step(3);
      check(8'(card_rst_n), 8'h01);
      // two characters 12 etus apart under a 16 etu limit: one timeout after the last
      wr(16'hFE1C, 8'h00);
      wr(16'hFE1D, 8'h10); // loaded before the card talks
      send(2);
      step(32 * 20);
      e_char++;
      events();
      drain();
      // block wait of 20 etus with junk in the unused top bits; mute card, then a reply
      wr(16'hFE18, 8'hF0);
      wr(16'hFE19, 8'h00);
      wr(16'hFE1A, 8'h00);
      wr(16'hFE1B, 8'h14); // loaded before the last transmit byte
      send_tx();
      step(32 * 13);
      e_wait++;
      events();
      send_tx();
      send(1);
      step(32 * 20);
      e_char++;
      events();
      drain();
      // answer overruns its 20 etu limit, then one that fits is cut off by the flag
      flag = 1'b1;
      wr(16'hFE1F, 8'h00);
      wr(16'hFE20, 8'h14);
      send(3);
      step(32 * 20);
      e_ans++;
      e_char++;
      events();
      drain();
      wr(16'hFE20, 8'h28);
      flag = 1'b0;
      step();
      flag = 1'b1;
      send(2);
      flag = 1'b0;
      step(32 * 50);
      e_char++;
      events();
      drain();
      // fill past 32 entries while nobody reads; the extra byte is lost
      // under t0 the work wait restarts on every char and expires after the last
      t1 = 1'b0;
      send(32);
      i_card.send_byte(8'hA5);
      step(32 * 20);
      e_char++;
      e_wait++;
      check(n_ovr, 8'h01);
      events();
      drain();
      // firmware owns framing and the line in bypass
      byp = 1'b1;
      drv = 1'b1;
      lvl = 1'($random(seed));
      step(4);
      check({6'h00, io_oe, io_out}, {7'h01, lvl});
      check(8'(smp), 8'(lvl));
      drv = 1'b0;
      step(4);
      check(8'(io_oe), 8'h00);
      byp = 1'b0;
      // the sync clock shows only on the selected interface
      sync = 1'b1;
      step(32 * 8);
      check(n_clk, 8'h00);
      sel = 1'b1; // software selects the interface
      step(32 * 8);
      check(8'(n_clk > 8'h02), 8'h01);
      close_out();
   end
endmodule : tb_top
`default_nettype wire
